/* core/vcxa_ctrl.sv */
// Crosspoint control: register slave, command execution, reply capture and autoselect
`include "vcxa_defines.svh"
module vcxa_ctrl #(
  parameter int N_IN = 4,
  parameter int N_OUT = 2,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`VCXA_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`VCXA_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Live port detection pins
  input wire vcxa_pkg::vcxa_live_t [N_IN-1:0] in_live,
  input wire vcxa_pkg::vcxa_live_t [N_OUT-1:0] out_live,
  // Crosspoint selection
  output logic [N_OUT-1:0][1:0] route_sel
);

  localparam int IW = 2;

  if (N_IN < 2 || N_IN > 4 || N_OUT < 1 || N_OUT > 2 || DEPTH > 63 ||
      DEPTH < 6 * N_IN - 1 || DEPTH < 2 * N_IN * N_OUT - 1) begin : g_bad_param
    $error("vcxa_ctrl: unsupported port counts or reply depth");
  end

  typedef struct packed {
    vcxa_pkg::vcxa_live_t [N_IN-1:0] in_s1;
    vcxa_pkg::vcxa_live_t [N_IN-1:0] in_s2;
    vcxa_pkg::vcxa_live_t [N_OUT-1:0] out_s1;
    vcxa_pkg::vcxa_live_t [N_OUT-1:0] out_s2;
    logic [N_IN-1:0] link_prev;
    logic [N_OUT-1:0][IW-1:0] route;
    vcxa_pkg::vcxa_auto_t [N_OUT-1:0] auto_set;
    logic [N_OUT-1:0][N_IN-1:0][1:0] rank;
    logic aw_got;
    logic w_got;
    logic [`VCXA_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [DEPTH-1:0][7:0] text;
    logic [5:0] len;
    vcxa_pkg::vcxa_kind_t kind;
    logic err;
    logic valid;
  } vcxa_state_t;

  function automatic vcxa_state_t reset_state();
    vcxa_state_t s;
    s = '0;
    s.link_prev = '1;
    for (int o = 0; o < N_OUT; o++) begin
      s.route[o] = `VCXA_ROUTE_RST;
      s.auto_set[o].en = `VCXA_AUTO_EN_RST;
      s.auto_set[o].mode = vcxa_pkg::VCXA_MODE_FIRST;
      s.auto_set[o].preempt = `VCXA_PREEMPT_RST;
      for (int i = 0; i < N_IN; i++) begin
        s.rank[o][i] = 2'(i);
      end
    end
    return s;
  endfunction

  localparam vcxa_state_t STATE_RST = reset_state();

  // Byte lanes that were not strobed are taken as zero
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  vcxa_state_t state_reg;
  vcxa_state_t state_next;
  vcxa_pkg::vcxa_op_t bld_op;
  logic [DEPTH-1:0][7:0] bld_text;
  logic [5:0] bld_len;

  // Builder reads the synchronised live state, so live replies trail the pins by two cycles
  vcxa_reply_builder #(
    .N_IN(N_IN),
    .N_OUT(N_OUT),
    .IW(IW),
    .DEPTH(DEPTH)
  ) u_reply (
    .op(bld_op),
    .in_live(state_reg.in_s2),
    .out_live(state_reg.out_s2),
    .route(state_reg.route),
    .auto_set(state_reg.auto_set),
    .rank(state_reg.rank),
    .text(bld_text),
    .len(bld_len)
  );

  assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign route_sel = state_reg.route;

  always_comb begin
    logic do_write, cmd_go, out_idx, idx_ok, cur_act, first_ok, best_ok, new_ok, act;
    logic [31:0] cmd;
    vcxa_pkg::vcxa_op_t op;
    logic [IW-1:0] in_idx, cur, first_i, best_i, new_i;
    logic [N_OUT-1:0] switched;
    logic [`VCXA_ADDR_W-1:0] ra;
    state_next = state_reg;
    do_write = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
    cmd_go = do_write && state_reg.awaddr[`VCXA_ADDR_W-1:2] == `VCXA_OFF_CMD >> 2;
    cmd = state_reg.wdata & lane_mask(state_reg.wstrb);
    op = vcxa_pkg::vcxa_op_t'(cmd[`VCXA_CMD_OP_LSB +: 4]);
    in_idx = cmd[`VCXA_CMD_IN_LSB +: IW];
    out_idx = cmd[`VCXA_CMD_OUT_LSB];
    idx_ok = 32'(in_idx) < N_IN && 32'(out_idx) < N_OUT;
    switched = '0;
    ra = s_axi_araddr;
    cur = '0;
    cur_act = 1'b0;
    first_i = '0;
    first_ok = 1'b0;
    best_i = '0;
    best_ok = 1'b0;
    new_i = '0;
    new_ok = 1'b0;
    act = 1'b0;
    bld_op = cmd_go ? op : vcxa_pkg::VCXA_OP_NONE;

    // Two-stage synchronisers; an unknown link keeps the attach memory, so reset fakes no edge
    state_next.in_s1 = in_live;
    state_next.in_s2 = state_reg.in_s1;
    state_next.out_s1 = out_live;
    state_next.out_s2 = state_reg.out_s1;
    for (int i = 0; i < N_IN; i++) begin
      state_next.link_prev[i] = vcxa_pkg::present(state_reg.in_s2[i].link) ||
        (state_reg.link_prev[i] && state_reg.in_s2[i].link == 2'b00);
    end

    // Write channels are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = cmd_go ? `VCXA_RESP_OKAY : `VCXA_RESP_DECERR;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Command execution
    if (cmd_go) begin
      state_next.valid = 1'b1;
      state_next.err = 1'b0;
      state_next.len = '0;
      state_next.kind = vcxa_pkg::VCXA_KIND_MO;
      unique case (op)
        vcxa_pkg::VCXA_OP_IN_STATE, vcxa_pkg::VCXA_OP_OUT_STATE, vcxa_pkg::VCXA_OP_ROUTE,
        vcxa_pkg::VCXA_OP_AUTO, vcxa_pkg::VCXA_OP_RANK: begin
          state_next.kind = vcxa_pkg::VCXA_KIND_PR;
          state_next.text = bld_text;
          state_next.len = bld_len;
        end
        vcxa_pkg::VCXA_OP_SWITCH: begin
          if (idx_ok) begin
            state_next.route[out_idx] = in_idx;
            switched[out_idx] = 1'b1;
          end else begin
            state_next.err = 1'b1;
          end
        end
        vcxa_pkg::VCXA_OP_SET_AUTO: begin
          if (!idx_ok) begin
            state_next.err = 1'b1;
          end else begin
            if (cmd[`VCXA_CMD_EN_VLD]) begin
              state_next.auto_set[out_idx].en = cmd[`VCXA_CMD_EN];
            end
            if (cmd[`VCXA_CMD_MODE_VLD]) begin
              state_next.auto_set[out_idx].mode =
                vcxa_pkg::vcxa_mode_t'(cmd[`VCXA_CMD_MODE_LSB +: 2]);
            end
            if (cmd[`VCXA_CMD_PRE_VLD]) begin
              state_next.auto_set[out_idx].preempt = cmd[`VCXA_CMD_PRE];
            end
            if (cmd[`VCXA_CMD_MODE_VLD] && cmd[`VCXA_CMD_MODE_LSB +: 2] == 2'b11) begin
              state_next.auto_set[out_idx].mode = state_reg.auto_set[out_idx].mode;
              state_next.err = 1'b1;
            end
          end
        end
        vcxa_pkg::VCXA_OP_SET_RANK: begin
          if (idx_ok) begin
            state_next.rank[out_idx][in_idx] = cmd[`VCXA_CMD_RANK_LSB +: 2];
          end else begin
            state_next.err = 1'b1;
          end
        end
        default: begin
          state_next.err = 1'b1;
        end
      endcase
    end

    // Autoselect; an explicit switch owns its output for that cycle
    for (int o = 0; o < N_OUT; o++) begin
      cur = state_reg.route[o];
      cur_act = vcxa_pkg::present(state_reg.in_s2[cur].signal);
      first_ok = 1'b0;
      best_ok = 1'b0;
      new_ok = 1'b0;
      first_i = '0;
      best_i = '0;
      new_i = '0;
      for (int i = N_IN - 1; i >= 0; i--) begin
        act = vcxa_pkg::present(state_reg.in_s2[i].signal);
        if (act) begin
          first_i = IW'(i);
          first_ok = 1'b1;
        end
        if (vcxa_pkg::present(state_reg.in_s2[i].link) && !state_reg.link_prev[i]) begin
          new_i = IW'(i);
          new_ok = 1'b1;
        end
        // Scanning downward with <= leaves the lowest number on a tie
        if (act && (!best_ok || state_reg.rank[o][i] <= state_reg.rank[o][best_i])) begin
          best_i = IW'(i);
          best_ok = 1'b1;
        end
      end
      if (state_reg.auto_set[o].en && !switched[o]) begin
        unique case (state_reg.auto_set[o].mode)
          vcxa_pkg::VCXA_MODE_FIRST: begin
            if (!cur_act && first_ok) begin
              state_next.route[o] = first_i;
            end
          end
          vcxa_pkg::VCXA_MODE_PRIO: begin
            if (best_ok && !cur_act) begin
              state_next.route[o] = best_i;
            end else if (best_ok && state_reg.auto_set[o].preempt && best_i != cur) begin
              state_next.route[o] = best_i;
            end
          end
          vcxa_pkg::VCXA_MODE_LAST: begin
            if (new_ok) begin
              state_next.route[o] = new_i;
            end
          end
          default: begin
            state_next.route[o] = cur;
          end
        endcase
      end
    end

    // Read channel
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = '0;
      state_next.rresp = `VCXA_RESP_OKAY;
      if (ra >= `VCXA_OFF_REPLY_TEXT && 32'(ra - `VCXA_OFF_REPLY_TEXT) < 4 * DEPTH) begin
        state_next.rdata = {24'h0, state_reg.text[(ra - `VCXA_OFF_REPLY_TEXT) >> 2]};
      end else if (ra >= `VCXA_OFF_IN_LIVE && 32'(ra - `VCXA_OFF_IN_LIVE) < 4 * N_IN) begin
        state_next.rdata = {22'h0, state_reg.in_s2[(ra - `VCXA_OFF_IN_LIVE) >> 2]};
      end else if (ra >= `VCXA_OFF_OUT_LIVE && 32'(ra - `VCXA_OFF_OUT_LIVE) < 4 * N_OUT) begin
        state_next.rdata = {22'h0, state_reg.out_s2[(ra - `VCXA_OFF_OUT_LIVE) >> 2]};
      end else begin
        unique case (ra[`VCXA_ADDR_W-1:2])
          `VCXA_OFF_CMD >> 2: begin
            state_next.rdata = '0;
          end
          `VCXA_OFF_REPLY_INFO >> 2: begin
            state_next.rdata[`VCXA_INFO_LEN_LSB +: 6] = state_reg.len;
            state_next.rdata[`VCXA_INFO_KIND] = state_reg.kind;
            state_next.rdata[`VCXA_INFO_ERR] = state_reg.err;
            state_next.rdata[`VCXA_INFO_VALID] = state_reg.valid;
          end
          `VCXA_OFF_ROUTE >> 2: begin
            state_next.rdata = 32'(state_reg.route);
          end
          `VCXA_OFF_AUTOPICK >> 2: begin
            state_next.rdata = 32'(state_reg.auto_set);
          end
          `VCXA_OFF_RANK >> 2: begin
            state_next.rdata = 32'(state_reg.rank);
          end
          default: begin
            state_next.rresp = `VCXA_RESP_DECERR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // vcxa_ctrl

/* core/vcxa_defines.svh */
// Register offsets, field positions, reset values and character codes of the crosspoint control
`ifndef VCXA_DEFINES_SVH
`define VCXA_DEFINES_SVH

`define VCXA_ADDR_W 8
`define VCXA_OFF_CMD 8'h00
`define VCXA_OFF_REPLY_INFO 8'h04
`define VCXA_OFF_ROUTE 8'h08
`define VCXA_OFF_AUTOPICK 8'h0c
`define VCXA_OFF_RANK 8'h10
`define VCXA_OFF_IN_LIVE 8'h20
`define VCXA_OFF_OUT_LIVE 8'h30
`define VCXA_OFF_REPLY_TEXT 8'h40

`define VCXA_CMD_OP_LSB 0
`define VCXA_CMD_IN_LSB 4
`define VCXA_CMD_OUT_LSB 6
`define VCXA_CMD_EN_VLD 8
`define VCXA_CMD_EN 9
`define VCXA_CMD_MODE_VLD 10
`define VCXA_CMD_MODE_LSB 11
`define VCXA_CMD_PRE_VLD 13
`define VCXA_CMD_PRE 14
`define VCXA_CMD_RANK_LSB 16

`define VCXA_INFO_LEN_LSB 0
`define VCXA_INFO_KIND 8
`define VCXA_INFO_ERR 9
`define VCXA_INFO_VALID 16

`define VCXA_AUTO_EN_RST 1'b0
`define VCXA_PREEMPT_RST 1'b0
`define VCXA_ROUTE_RST 2'h0

`define VCXA_RESP_OKAY 2'h0
`define VCXA_RESP_DECERR 2'h3

`define VCXA_CH_T 8'h54
`define VCXA_CH_L 8'h4c
`define VCXA_CH_M 8'h4d
`define VCXA_CH_U 8'h55
`define VCXA_CH_E 8'h45
`define VCXA_CH_D 8'h44
`define VCXA_CH_F 8'h46
`define VCXA_CH_P 8'h50
`define VCXA_CH_I 8'h49
`define VCXA_CH_ZERO 8'h30
`define VCXA_CH_HEX_A 8'h37
`define VCXA_CH_SEMI 8'h3b
`define VCXA_CH_COMMA 8'h2c

`endif

/* core/vcxa_pkg.sv */
// Types and shared encoding functions of the crosspoint control
`include "vcxa_defines.svh"
package vcxa_pkg;

  typedef struct packed {
    logic mute;
    logic lock;
    logic [1:0] audio;
    logic [1:0] crypt;
    logic [1:0] signal;
    logic [1:0] link;
  } vcxa_live_t;

  typedef enum logic [3:0] {
    VCXA_OP_NONE,
    VCXA_OP_IN_STATE,
    VCXA_OP_OUT_STATE,
    VCXA_OP_ROUTE,
    VCXA_OP_AUTO,
    VCXA_OP_RANK,
    VCXA_OP_SWITCH,
    VCXA_OP_SET_AUTO,
    VCXA_OP_SET_RANK
  } vcxa_op_t;

  typedef enum logic [1:0] {
    VCXA_MODE_FIRST,
    VCXA_MODE_PRIO,
    VCXA_MODE_LAST
  } vcxa_mode_t;

  typedef struct packed {
    logic en;
    vcxa_mode_t mode;
    logic preempt;
  } vcxa_auto_t;

  typedef enum logic {
    VCXA_KIND_PR,
    VCXA_KIND_MO
  } vcxa_kind_t;

  function automatic logic present(input logic [1:0] f);
    return f == 2'b11;
  endfunction

  function automatic logic [7:0] lock_letter(input vcxa_live_t s);
    logic [7:0] c;
    unique case ({s.mute, s.lock})
      2'b00: c = `VCXA_CH_T;
      2'b01: c = `VCXA_CH_L;
      2'b10: c = `VCXA_CH_M;
      2'b11: c = `VCXA_CH_U;
    endcase
    return c;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? `VCXA_CH_ZERO + {4'h0, n} : `VCXA_CH_HEX_A + {4'h0, n};
  endfunction

  // Upper byte is reserved and always zero
  function automatic logic [15:0] status_code(input vcxa_live_t s);
    return {8'h00, s.audio, s.crypt, s.signal, s.link};
  endfunction

  function automatic logic [7:0] mode_letter(input vcxa_mode_t m);
    logic [7:0] c;
    unique case (m)
      VCXA_MODE_FIRST: c = `VCXA_CH_F;
      VCXA_MODE_PRIO: c = `VCXA_CH_P;
      VCXA_MODE_LAST: c = `VCXA_CH_L;
      default: c = `VCXA_CH_F;
    endcase
    return c;
  endfunction

endpackage

/* core/vcxa_reply_builder.sv */
// Combinational text builder for the property read replies
module vcxa_reply_builder #(
  parameter int N_IN = 4,
  parameter int N_OUT = 2,
  parameter int IW = 2,
  parameter int DEPTH = 32
) (
  // Query and live state
  input wire vcxa_pkg::vcxa_op_t op,
  input wire vcxa_pkg::vcxa_live_t [N_IN-1:0] in_live,
  input wire vcxa_pkg::vcxa_live_t [N_OUT-1:0] out_live,
  input wire logic [N_OUT-1:0][IW-1:0] route,
  input wire vcxa_pkg::vcxa_auto_t [N_OUT-1:0] auto_set,
  input wire logic [N_OUT-1:0][N_IN-1:0][1:0] rank,
  // Reply text
  output logic [DEPTH-1:0][7:0] text,
  output logic [5:0] len
);

  function automatic logic [39:0] entry(input vcxa_pkg::vcxa_live_t s);
    logic [15:0] c;
    c = vcxa_pkg::status_code(s);
    return {vcxa_pkg::lock_letter(s), vcxa_pkg::hex_char(c[15:12]),
            vcxa_pkg::hex_char(c[11:8]), vcxa_pkg::hex_char(c[7:4]),
            vcxa_pkg::hex_char(c[3:0])};
  endfunction

  always_comb begin
    int n;
    logic [39:0] e;
    n = 0;
    e = '0;
    text = '0;
    unique case (op)
      vcxa_pkg::VCXA_OP_IN_STATE: begin
        for (int i = 0; i < N_IN; i++) begin
          if (i > 0) begin
            text[n] = `VCXA_CH_SEMI;
            n++;
          end
          e = entry(in_live[i]);
          for (int k = 0; k < 5; k++) begin
            text[n] = e[39-8*k -: 8];
            n++;
          end
        end
      end
      vcxa_pkg::VCXA_OP_OUT_STATE: begin
        for (int o = 0; o < N_OUT; o++) begin
          if (o > 0) begin
            text[n] = `VCXA_CH_SEMI;
            n++;
          end
          e = entry(out_live[o]);
          for (int k = 0; k < 5; k++) begin
            text[n] = e[39-8*k -: 8];
            n++;
          end
        end
      end
      vcxa_pkg::VCXA_OP_ROUTE: begin
        for (int o = 0; o < N_OUT; o++) begin
          if (o > 0) begin
            text[n] = `VCXA_CH_SEMI;
            n++;
          end
          text[n] = `VCXA_CH_I;
          text[n+1] = vcxa_pkg::hex_char(4'(route[o]) + 4'h1);
          n = n + 2;
        end
      end
      vcxa_pkg::VCXA_OP_AUTO: begin
        for (int o = 0; o < N_OUT; o++) begin
          if (o > 0) begin
            text[n] = `VCXA_CH_SEMI;
            n++;
          end
          text[n] = auto_set[o].en ? `VCXA_CH_E : `VCXA_CH_D;
          text[n+1] = vcxa_pkg::mode_letter(auto_set[o].mode);
          n = n + 2;
          if (auto_set[o].preempt) begin
            text[n] = `VCXA_CH_M;
            n++;
          end
        end
      end
      vcxa_pkg::VCXA_OP_RANK: begin
        for (int o = 0; o < N_OUT; o++) begin
          for (int i = 0; i < N_IN; i++) begin
            if (i > 0) begin
              text[n] = `VCXA_CH_COMMA;
              n++;
            end else if (o > 0) begin
              text[n] = `VCXA_CH_SEMI;
              n++;
            end
            text[n] = vcxa_pkg::hex_char({2'b00, rank[o][i]});
            n++;
          end
        end
      end
      vcxa_pkg::VCXA_OP_NONE, vcxa_pkg::VCXA_OP_SWITCH, vcxa_pkg::VCXA_OP_SET_AUTO,
      vcxa_pkg::VCXA_OP_SET_RANK: begin
        n = 0;
      end
      default: begin
        n = 0;
      end
    endcase
    len = 6'(n);
  end

endmodule // vcxa_reply_builder

/* verification/vcxa_ctrl_asserts.sv */
// Port assertions of the crosspoint control
module vcxa_ctrl_asserts #(
  parameter int N_IN = 4,
  parameter int N_OUT = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Live pins and selection
  input wire vcxa_pkg::vcxa_live_t [N_IN-1:0] in_live,
  input wire logic [N_OUT-1:0][1:0] route_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Cycles since the live pins last moved; covers synchroniser plus pick latency
  logic [3:0] quiet;
  vcxa_pkg::vcxa_live_t [N_IN-1:0] live_q;
  always_ff @(posedge ref_clk) begin
    live_q <= in_live;
    quiet <= (!rst_b || in_live != live_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
  end
  chk_b_after_take: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
    else $error("write answer not two edges after take");
  chk_b_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_r_next_edge: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_has_cause: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  chk_r_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_route_cause: assert property ($changed(route_sel) |->
    s_axi_bvalid || $past(s_axi_bvalid) || quiet < 4'h6)
    else $error("selection moved without command or live change");
endmodule  // vcxa_ctrl_asserts

/* verification/vcxa_host.sv */
// Host model: AXI4-Lite master that issues command words and reads replies
module vcxa_host (
  // Clock
  input wire logic ref_clk,
  // Write side
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read side
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Answer readies stay high, so no answer is left waiting
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge ref_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge ref_clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule  // vcxa_host

/* verification/video_crosspoint_autoselect_ctrl_test.sv */
// Self-checking bench of the crosspoint control
`include "vcxa_defines.svh"
module video_crosspoint_autoselect_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] c; logic [191:0] t;} vcxa_row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  vcxa_pkg::vcxa_live_t [3:0] in_live = {10'h3ff, 10'h2bf, 10'h1af, 10'h00a};
  vcxa_pkg::vcxa_live_t [1:0] out_live = {10'h0ef, 10'h2bf};
  logic [1:0][1:0] route_sel;
  logic [191:0] t;
  logic [31:0] info, d;
  logic [1:0] r;
  int failures = 0;
  int tests_run = 0;
  vcxa_row_t rows [18] = '{
    '{32'h3, "I1;I1"},
    '{32'h4, "DF;DF"},
    '{32'h5, "0,1,2,3;0,1,2,3"},
    '{32'h1, "T000A;L00AF;M00BF;U00FF"},
    '{32'h2, "M00BF;T00EF"},
    '{32'h66, ""},
    '{32'h3, "I1;I3"},
    '{32'h6f07, ""},
    '{32'h4, "EPM;DF"},
    '{32'h3, "I2;I3"},
    '{32'h107, ""},
    '{32'h4, "DPM;DF"},
    '{32'h38, ""},
    '{32'h5, "0,1,2,0;0,1,2,3"},
    '{32'h307, ""},
    '{32'h3, "I4;I3"},
    '{32'h18, ""},
    '{32'h3, "I2;I3"}
  };
  always #5 ref_clk = ~ref_clk;
  vcxa_ctrl uut (.ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .in_live, .out_live, .route_sel);
  vcxa_host h (.ref_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  task automatic check(string what, logic [191:0] seen, logic [191:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Command, then reply info, then one character per word
  task automatic exec(input logic [31:0] c, output logic [191:0] txt, output logic [31:0] inf);
    logic [1:0] rr;
    logic [31:0] ch;
    txt = 192'h0;
    h.wr(`VCXA_OFF_CMD, c, rr);
    h.rd(`VCXA_OFF_REPLY_INFO, inf, rr);
    for (int k = 0; k < int'(inf[5:0]); k++) begin
      h.rd(`VCXA_OFF_REPLY_TEXT + 8'(4 * k), ch, rr);
      txt = {txt[183:0], ch[7:0]};
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    results();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      exec(rows[i].c, t, info);
      check("reply text", t, rows[i].t);
      check("reply kind", 192'(info[9:8]), (rows[i].t == 192'h0) ? 192'h1 : 192'h0);
      $display("row %0d done", i);
    end
    exec(32'h0, t, info);
    check("bad op", 192'(info[9]), 192'h1);
    exec(32'h1c07, t, info);
    check("bad mode", 192'(info[9]), 192'h1);
    exec(32'h4, t, info);
    check("mode kept", t, "EPM;DF");
    h.rd(8'h14, d, r);
    check("unmapped read", 192'(r), 192'(`VCXA_RESP_DECERR));
    h.wr(`VCXA_OFF_ROUTE, 32'h5, r);
    check("read-only write", 192'(r), 192'(`VCXA_RESP_DECERR));
    exec(32'h3, t, info);
    check("route kept", t, "I2;I3");
    $display("refusals done");
    exec(32'h1747, t, info);
    in_live[0].link <= 2'h3;
    repeat (6) @(posedge ref_clk);
    check("last pick", 192'(route_sel[1]), 192'h0);
    exec(32'h0747, t, info);
    check("first pick", 192'(route_sel[1]), 192'h1);
    in_live[3] <= 10'h00a;
    repeat (4) @(posedge ref_clk);
    exec(32'h1, t, info);
    check("live status", t, "T000B;L00AF;M00BF;T000A");
    $display("autoselect done");
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    check("reset route", 192'(route_sel), 192'h0);
    exec(32'h4, t, info);
    check("reset auto", t, "DF;DF");
    $display("reset done");
    results();
  end
endmodule  // video_crosspoint_autoselect_ctrl_test
bind vcxa_ctrl vcxa_ctrl_asserts #(.N_IN(N_IN), .N_OUT(N_OUT)) chk (.ref_clk, .rst_b,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .in_live, .route_sel);
